// ---- design/setpoint_pkg.sv ----
package setpoint_pkg;

    // ----------------------------------------------------------------
    // clock and timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned DELAY_STEP_NS = 100_000_000; // 0.1 s delay step
    localparam int unsigned DELAY_MAX     = 5999;        // 599.9 s in steps

    // ----------------------------------------------------------------
    // value ranges
    // ----------------------------------------------------------------
    localparam int SP_MIN   = -19999;
    localparam int SP_MAX   = 99999;
    localparam int HYST_MIN = 1;
    localparam int HYST_MAX = 59999;

    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_GCTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS  = 8'h04;
    localparam logic [7:0] REG_OFFSET  = 8'h08;
    localparam logic [3:0] CH0_PAGE    = 4'h1;  // channel 0 at 0x10..0x1C
    localparam logic [3:0] CH1_PAGE    = 4'h2;  // channel 1 at 0x20..0x2C
    localparam logic [3:0] CH_CTRL     = 4'h0;
    localparam logic [3:0] CH_SETPOINT = 4'h4;
    localparam logic [3:0] CH_HYST     = 4'h8;
    localparam logic [3:0] CH_DELAYS   = 4'hC;
    localparam int         OFF_DLY_POS = 16;    // off delay field in CH_DELAYS

    // ----------------------------------------------------------------
    // encodings
    // ----------------------------------------------------------------
    localparam logic [1:0] HIGH_ACTING_BALANCED   = 2'h0;
    localparam logic [1:0] HIGH_ACTING_UNBALANCED = 2'h1;
    localparam logic [1:0] LOW_ACTING_BALANCED    = 2'h2;
    localparam logic [1:0] LOW_ACTING_UNBALANCED  = 2'h3;

    localparam logic [1:0] RM_AUTO                  = 2'h0;
    localparam logic [1:0] RM_LATCH_IMMEDIATE_RESET = 2'h1;
    localparam logic [1:0] RM_LATCH_DELAYED_RESET   = 2'h2;

    localparam logic [2:0] UF_NONE  = 3'h0;
    localparam logic [2:0] UF_ZERO  = 3'h1;
    localparam logic [2:0] UF_RESET = 3'h2;
    localparam logic [2:0] UF_SP1   = 3'h3;
    localparam logic [2:0] UF_SP2   = 3'h4;
    localparam logic [2:0] UF_BOTH  = 3'h5;

    // ----------------------------------------------------------------
    // state types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       standby_en;
        logic       out_rst_disp;
        logic [1:0] rmode;
        logic [1:0] action;
        logic       en;
    } ch_cfg_t;

    typedef struct packed {
        logic       input_shown;
        logic       zero_en;
        logic       key_disp;
        logic       key_en;
        logic       ui_disp;
        logic [2:0] ui_func;
        logic       ui_high;
    } gctrl_t;

    typedef struct packed {
        ch_cfg_t            cfg;
        logic signed [17:0] sp;
        logic [15:0]        hys;
        logic [12:0]        don;
        logic [12:0]        doff;
        logic [12:0]        tmr;
        logic               out;
        logic               pend;
        logic               sby;
        logic               blk;
    } ch_state_t;

    typedef struct packed {
        ch_state_t [1:0]    ch;
        gctrl_t             g;
        logic signed [17:0] ofs;
        logic [23:0]        div;
        logic               key_q;
        logic               ui_q;
        logic [31:0]        rdata;
    } state_t;

    localparam ch_cfg_t   CFG_RST = '0;
    localparam gctrl_t    G_RST   = '{input_shown: 1'b1, default: '0};
    localparam logic [15:0] HYST_RST = 16'h0001;

endpackage

// ---- design/setpoint_outputs.sv ----
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns

// Functional notes
// - four actions: high/low, balanced/unbalanced
// - setpoint accepted from -19999 to 99999
// - hysteresis accepted from 1 to 59999
// - unbalanced band below high, above low
// - on delay 0.0 to 599.9 s
// - separate off delay 0.0 to 599.9 s
// - zero delay switches at normal rate
// - auto: self off, manual reset forces off
// - immediate latch held until manual reset
// - latched outputs come up off
// - delayed latch: reset waits for off point
// - power cycle drops pending delayed reset
// - display reset may also reset outputs
// - output reset needs display assignment, shown
// - standby holds output until first crossing
// - reset key resets assigned values
// - display reset stores zeroing offset
// - zeroing needs input shown; user input zero needs no display assignment
// - disabled setpoint takes no part
// - user input resets output 1, 2, both
// - user input level applied first
module setpoint_outputs
    import setpoint_pkg::*;
#(
    parameter int unsigned TICK_CYC = DELAY_STEP_NS / CLK_PERIOD_NS
) (
    // clock and reset
    input  wire logic               mclk,
    input  wire logic               rst_b,
    // register port
    input  wire logic [7:0]         addr,
    input  wire logic [31:0]        wr_data,
    input  wire logic               wr_en,
    input  wire logic               rd_en,
    output logic      [31:0]        rd_data,
    // meter side
    input  wire logic signed [17:0] disp_value,
    input  wire logic               reset_key,
    input  wire logic               user_in,
    // relay drivers
    output logic      [1:0]         sp_out
);

    // ----------------------------------------------------------------
    // state and event signals
    // ----------------------------------------------------------------
    state_t      s_r;
    state_t      s_nxt;
    logic        tick;
    logic        key_ev;
    logic        ui_ev;
    logic        disp_rst;
    logic [1:0]  cond_on;
    logic [1:0]  cond_off;
    logic [1:0]  hold;
    logic [1:0]  ch_rst;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------

    // one process computes every next value from s_r
    always_comb begin
        logic               ui_lvl;
        logic signed [19:0] v;
        logic signed [19:0] spx;
        logic signed [19:0] hy;
        logic signed [19:0] half;
        logic signed [19:0] on_th;
        logic signed [19:0] off_th;
        logic [12:0]        dly;
        logic               go_on;
        logic               go_off;
        logic [1:0]         pg;
        int                 c;
        ui_lvl   = 1'b0;
        v        = '0;
        spx      = '0;
        hy       = '0;
        half     = '0;
        on_th    = '0;
        off_th   = '0;
        dly      = '0;
        go_on    = 1'b0;
        go_off   = 1'b0;
        pg       = '0;
        c        = 0;
        s_nxt    = s_r;
        s_nxt.rdata = '0;
        cond_on  = '0;
        cond_off = '0;
        hold     = '0;
        ch_rst   = '0;

        // delay step divider, one pulse per tenth of a second
        tick = (s_r.div == 24'(TICK_CYC - 1));
        s_nxt.div = tick ? '0 : s_r.div + 24'h000001;

        // input level applied before the edge is taken
        ui_lvl = s_r.g.ui_high ? user_in : ~user_in;
        s_nxt.key_q = reset_key;
        s_nxt.ui_q  = ui_lvl;
        key_ev = reset_key & ~s_r.key_q & s_r.g.key_en;
        ui_ev  = ui_lvl & ~s_r.ui_q;

        // display reset only when assigned to and showing the input
        disp_rst = s_r.g.input_shown & ((key_ev & s_r.g.key_disp) |
                   (ui_ev & s_r.g.ui_disp & (s_r.g.ui_func == UF_RESET)));

        // zeroing offset taken from the current reading
        if ((disp_rst & s_r.g.zero_en) | (ui_ev & (s_r.g.ui_func == UF_ZERO) &
                                          s_r.g.input_shown)) begin
            s_nxt.ofs = disp_value;
        end

        // register writes; out-of-range values are refused
        pg = (addr[7:4] == CH1_PAGE) ? 2'h1 : 2'h0;
        if (wr_en) begin
            if (addr == REG_GCTRL) begin
                s_nxt.g = gctrl_t'(wr_data[$bits(gctrl_t)-1:0]);
            end else if (addr[7:4] == CH0_PAGE || addr[7:4] == CH1_PAGE) begin
                unique case (addr[3:0])
                    CH_CTRL: s_nxt.ch[pg[0]].cfg = ch_cfg_t'(wr_data[$bits(ch_cfg_t)-1:0]);
                    CH_SETPOINT: begin
                        if ($signed(wr_data) >= SP_MIN && $signed(wr_data) <= SP_MAX) begin
                            s_nxt.ch[pg[0]].sp = wr_data[17:0];
                        end
                    end
                    CH_HYST: begin
                        if (wr_data >= 32'(HYST_MIN) && wr_data <= 32'(HYST_MAX)) begin
                            s_nxt.ch[pg[0]].hys = wr_data[15:0];
                        end
                    end
                    CH_DELAYS: begin
                        if (wr_data[12:0] <= 13'(DELAY_MAX)) begin
                            s_nxt.ch[pg[0]].don = wr_data[12:0];
                        end
                        if (wr_data[OFF_DLY_POS+:13] <= 13'(DELAY_MAX)) begin
                            s_nxt.ch[pg[0]].doff = wr_data[OFF_DLY_POS+:13];
                        end
                    end
                    default: ;
                endcase
            end
        end

        // per-channel trigger, delay and reset handling
        v = 20'(disp_value) - 20'(s_r.ofs);
        for (c = 0; c < 2; c++) begin
            spx  = 20'(s_r.ch[c].sp);
            hy   = $signed({4'h0, s_r.ch[c].hys});
            half = hy >>> 1;
            unique case (s_r.ch[c].cfg.action)
                HIGH_ACTING_BALANCED: begin
                    on_th  = spx + half;
                    off_th = spx - half;
                end
                HIGH_ACTING_UNBALANCED: begin
                    on_th  = spx;
                    off_th = spx - hy;
                end
                LOW_ACTING_BALANCED: begin
                    on_th  = spx - half;
                    off_th = spx + half;
                end
                LOW_ACTING_UNBALANCED: begin
                    on_th  = spx;
                    off_th = spx + hy;
                end
            endcase
            cond_on[c]  = s_r.ch[c].cfg.action[1] ? (v <= on_th) : (v >= on_th);
            cond_off[c] = s_r.ch[c].cfg.action[1] ? (v > off_th) : (v < off_th);
            hold[c] = (s_r.ch[c].sby & s_r.ch[c].cfg.standby_en) | s_r.ch[c].blk;
            // key not assigned to the display acts as a plain manual output reset
            ch_rst[c] = (key_ev & ~s_r.g.key_disp) |
                        (disp_rst & s_r.ch[c].cfg.out_rst_disp) |
                        (ui_ev & ((s_r.g.ui_func == UF_BOTH) |
                                  (s_r.g.ui_func == (c == 0 ? UF_SP1 : UF_SP2))));

            if (!s_r.ch[c].cfg.en) begin
                // disabled channel is parked and ignores its setup
                s_nxt.ch[c].out  = 1'b0;
                s_nxt.ch[c].tmr  = '0;
                s_nxt.ch[c].pend = 1'b0;
                s_nxt.ch[c].blk  = 1'b0;
            end else begin
                // crossing into the off region releases standby and block
                if (cond_off[c]) begin
                    s_nxt.ch[c].sby = 1'b0;
                    s_nxt.ch[c].blk = 1'b0;
                end
                go_on  = cond_on[c] & ~s_r.ch[c].out & ~hold[c];
                go_off = cond_off[c] & s_r.ch[c].out &
                         ((s_r.ch[c].cfg.rmode == RM_AUTO) |
                          ((s_r.ch[c].cfg.rmode == RM_LATCH_DELAYED_RESET) &
                           s_r.ch[c].pend));
                dly = go_on ? s_r.ch[c].don : s_r.ch[c].doff;
                if (go_on | go_off) begin
                    if (s_r.ch[c].tmr >= dly) begin
                        s_nxt.ch[c].out = go_on;
                        s_nxt.ch[c].tmr = '0;
                        if (go_off) begin
                            s_nxt.ch[c].pend = 1'b0;
                        end
                    end else if (tick) begin
                        s_nxt.ch[c].tmr = s_r.ch[c].tmr + 13'h0001;
                    end
                end else begin
                    s_nxt.ch[c].tmr = '0;
                end
                // manual reset: delayed mode only arms, others drop at once
                if (ch_rst[c] & s_r.ch[c].out) begin
                    if (s_r.ch[c].cfg.rmode == RM_LATCH_DELAYED_RESET) begin
                        s_nxt.ch[c].pend = 1'b1;
                    end else begin
                        s_nxt.ch[c].out = 1'b0;
                        s_nxt.ch[c].tmr = '0;
                        s_nxt.ch[c].blk = 1'b1;
                    end
                end
            end
        end

        // read data stands one cycle after the strobe; unmapped reads zero
        if (rd_en) begin
            if (addr == REG_GCTRL) begin
                s_nxt.rdata = 32'(s_r.g);
            end else if (addr == REG_STATUS) begin
                s_nxt.rdata = {24'h000000, hold, s_r.ch[1].pend, s_r.ch[0].pend,
                               2'h0, s_r.ch[1].out, s_r.ch[0].out};
            end else if (addr == REG_OFFSET) begin
                s_nxt.rdata = 32'(s_r.ofs);
            end else if (addr[7:4] == CH0_PAGE || addr[7:4] == CH1_PAGE) begin
                unique case (addr[3:0])
                    CH_CTRL:     s_nxt.rdata = 32'(s_r.ch[pg[0]].cfg);
                    CH_SETPOINT: s_nxt.rdata = 32'(s_r.ch[pg[0]].sp);
                    CH_HYST:     s_nxt.rdata = 32'(s_r.ch[pg[0]].hys);
                    CH_DELAYS:   s_nxt.rdata = {3'h0, s_r.ch[pg[0]].doff, 3'h0, s_r.ch[pg[0]].don};
                    default:     s_nxt.rdata = '0;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------

    // power-up: outputs off, pending resets dropped, standby armed
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '0;
            s_r.g <= G_RST;
            for (int i = 0; i < 2; i++) begin
                s_r.ch[i].cfg <= CFG_RST;
                s_r.ch[i].hys <= HYST_RST;
                s_r.ch[i].out <= 1'b0;
                s_r.ch[i].pend <= 1'b0;
                s_r.ch[i].sby <= 1'b1;
            end
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rd_data = s_r.rdata;
    assign sp_out  = {s_r.ch[1].out, s_r.ch[0].out};

    // ----------------------------------------------------------------
    // checks on channel 0, the user input edge and the zeroing offset
    // ----------------------------------------------------------------
    dis_off_a: assert property (@(posedge mclk) disable iff (!rst_b)
        !s_r.ch[0].cfg.en |=> !s_r.ch[0].out)
        else $error("disabled setpoint drove its output");

    zero_delay_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (s_r.ch[0].cfg.en && s_r.ch[0].don == 13'h0000 && cond_on[0] && !s_r.ch[0].out
         && !hold[0] && !ch_rst[0]) |=> s_r.ch[0].out)
        else $error("zero on delay did not switch next cycle");

    latch_keep_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (s_r.ch[0].cfg.en && s_r.ch[0].cfg.rmode == RM_LATCH_IMMEDIATE_RESET
         && s_r.ch[0].out && !ch_rst[0]) |=> s_r.ch[0].out)
        else $error("latched output dropped without reset");

    imm_reset_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (s_r.ch[0].cfg.en && s_r.ch[0].cfg.rmode != RM_LATCH_DELAYED_RESET
         && s_r.ch[0].out && ch_rst[0]) |=> !s_r.ch[0].out ##1 !s_r.ch[0].out)
        else $error("manual reset did not turn output off");

    dly_pend_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (s_r.ch[0].cfg.en && s_r.ch[0].cfg.rmode == RM_LATCH_DELAYED_RESET
         && s_r.ch[0].out && ch_rst[0]) |=> (s_r.ch[0].out && s_r.ch[0].pend))
        else $error("delayed reset not held pending");

    on_delay_a: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(s_r.ch[0].out) |-> $past(s_r.ch[0].tmr) >= $past(s_r.ch[0].don))
        else $error("output turned on before its delay");

    restart_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (s_r.ch[0].cfg.en && !s_r.ch[0].out && !cond_on[0]) |=> s_r.ch[0].tmr == 13'h0000)
        else $error("on timer not restarted on reversal");

    edge_once_a: assert property (@(posedge mclk) disable iff (!rst_b)
        ui_ev |=> !ui_ev)
        else $error("user input event longer than one cycle");

    zero_gate_a: assert property (@(posedge mclk) disable iff (!rst_b)
        $changed(s_r.ofs) |-> $past(s_r.g.input_shown))
        else $error("display zeroed while input not shown");

endmodule

// ---- tb/front_panel_model.sv ----
`timescale 1ns/1ns

// ----------------------------------------------------------------
// front panel model: reset key and user input contact
// ----------------------------------------------------------------
module front_panel_model #(
    parameter int HOLD = 4
) (
    // clock
    input  wire logic mclk,
    // contacts toward the meter
    output logic      reset_key,
    output logic      user_in
);
    // idle: key released, user input pulled up
    initial begin
        reset_key = 1'b0;
        user_in   = 1'b1;
    end

    // a press lasts several cycles, like a finger, not a one-cycle strobe
    task automatic press_key();
        @(posedge mclk);
        reset_key <= 1'b1;
        repeat (HOLD) @(posedge mclk);
        reset_key <= 1'b0;
    endtask

    // contact level, changed just after an edge
    task automatic set_user(input logic lvl);
        @(posedge mclk);
        user_in <= lvl;
    endtask
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/1ns

module tb;
    import setpoint_pkg::*;

    // ----------------------------------------------------------------
    // signals and design
    // ----------------------------------------------------------------
    logic               mclk;
    logic               rst_b;
    logic [7:0]         addr;
    logic [31:0]        wr_data;
    logic               wr_en;
    logic               rd_en;
    logic [31:0]        rd_data;
    logic signed [17:0] disp_value;
    logic               reset_key;
    logic               user_in;
    logic [1:0]         sp_out;
    int                 mismatches;
    int                 samples_checked;
    logic [31:0]        rv;
    logic               lh;
    logic [7:0]         ra [8] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h1C, 8'hFC};
    logic [31:0]        rx [8] = '{32'h100, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1, 32'h0, 32'h0};
    logic [2:0]         fn [3] = '{UF_SP1, UF_SP2, UF_BOTH};
    logic [1:0]         fx [3] = '{2'b10, 2'b01, 2'b00};

    // short delay step keeps the timed cases to tens of cycles
    setpoint_outputs #(.TICK_CYC(10)) dut_u (
        .mclk(mclk), .rst_b(rst_b), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .disp_value(disp_value),
        .reset_key(reset_key), .user_in(user_in), .sp_out(sp_out)
    );

    front_panel_model #(.HOLD(4)) front_u (
        .mclk(mclk), .reset_key(reset_key), .user_in(user_in)
    );

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // ----------------------------------------------------------------
    // access and check tasks
    // ----------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge mclk);
        wr_en   <= 1'b0;
    endtask

    // data stand only in the cycle after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1;
        d = rd_data;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        chk(d, exp);
    endtask

    function automatic logic [31:0] ctl(input logic [1:0] act, input logic [1:0] rm, input logic [1:0] ex);
        return {25'h0, ex, rm, act, 1'b1};
    endfunction

    // control word last, so a channel that it enables never runs on half a setup
    task automatic setch(input logic [3:0] pg, input logic [31:0] c, input logic [31:0] sp, input logic [31:0] dl);
        wr({pg, CH_SETPOINT}, sp);
        wr({pg, CH_HYST}, 32'd10);
        wr({pg, CH_DELAYS}, dl);
        wr({pg, CH_CTRL}, c);
    endtask

    task automatic chko(input int n, input logic [1:0] exp);
        repeat (n) @(posedge mclk);
        #1;
        chk({30'h0, sp_out}, {30'h0, exp});
    endtask

    task automatic outv(input logic [31:0] v, input logic [1:0] exp);
        @(posedge mclk);
        disp_value <= v[17:0];
        chko(3, exp);
    endtask

    task automatic wait_out(input logic [1:0] exp, input int lim);
        int n;
        n = 0;
        while (sp_out !== exp && n < lim) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk({30'h0, sp_out}, {30'h0, exp});
        if (n >= lim) begin
            tally_and_finish();
        end
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        rst_b = 1'b0;
        addr = 8'h00;
        wr_data = 32'h0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        disp_value = '0;
        mismatches = 0;
        samples_checked = 0;
        repeat (10) @(posedge mclk);
        rst_b <= 1'b1;
        // reset values, unmapped address last
        for (int i = 0; i < 8; i++) begin
            rdc(ra[i], rx[i]);
        end
        // range limits of the stored values
        wr(8'h14, 32'd99999);
        wr(8'h14, 32'd100000);
        rdc(8'h14, 32'd99999);
        wr(8'h14, -32'sd19999);
        wr(8'h14, -32'sd20000);
        rdc(8'h14, 32'hFFFF_B1E1);
        wr(8'h18, 32'd0);
        rdc(8'h18, 32'h1);
        wr(8'h18, 32'd59999);
        wr(8'h18, 32'd60000);
        rdc(8'h18, 32'd59999);
        wr(8'h1C, {16'd6000, 16'd5999});
        rdc(8'h1C, 32'd5999);
        wr(8'h1C, {16'd5999, 16'd6000});
        rdc(8'h1C, {16'd5999, 16'd5999});
        // four actions; channel 2 configured but not enabled must stay off
        wr({CH1_PAGE, CH_CTRL}, ctl(HIGH_ACTING_BALANCED, RM_AUTO, 2'b00) & 32'hFFFF_FFFE);
        for (int a = 0; a < 4; a++) begin
            int on_t;
            int off_t;
            int dir;
            logic hi;
            logic bal;
            hi    = (a[1:0] == HIGH_ACTING_BALANCED) || (a[1:0] == HIGH_ACTING_UNBALANCED);
            bal   = (a[1:0] == HIGH_ACTING_BALANCED) || (a[1:0] == LOW_ACTING_BALANCED);
            dir   = hi ? 1 : -1;
            on_t  = bal ? 100 + dir * 5 : 100;
            off_t = bal ? 100 - dir * 5 : 100 - dir * 10;
            setch(CH0_PAGE, ctl(a[1:0], RM_AUTO, 2'b00), 32'd100, 32'd0);
            outv(hi ? 80 : 120, 2'b00);
            outv(on_t - dir, 2'b00);
            outv(on_t, 2'b01);
            outv(off_t, 2'b01);
            outv(off_t - dir, 2'b00);
        end
        // on and off delays, with an interrupted on condition
        setch(CH0_PAGE, ctl(HIGH_ACTING_UNBALANCED, RM_AUTO, 2'b00), 32'd100, {16'd2, 16'd3});
        outv(80, 2'b00);
        outv(100, 2'b00);
        chko(14, 2'b00);
        outv(95, 2'b00);
        outv(100, 2'b00);
        chko(14, 2'b00);
        wait_out(2'b01, 40);
        outv(80, 2'b01);
        chko(7, 2'b01);
        wait_out(2'b00, 40);
        // key reset: ignored while disabled, then forces an automatic output off
        setch(CH0_PAGE, ctl(HIGH_ACTING_UNBALANCED, RM_AUTO, 2'b00), 32'd100, 32'd0);
        outv(120, 2'b01);
        front_u.press_key();
        chko(3, 2'b01);
        wr(REG_GCTRL, 32'h120);
        front_u.press_key();
        chko(3, 2'b00);
        outv(80, 2'b00);
        outv(120, 2'b01);
        outv(80, 2'b00);
        // latch with immediate reset
        setch(CH0_PAGE, ctl(HIGH_ACTING_UNBALANCED, RM_LATCH_IMMEDIATE_RESET, 2'b00), 32'd100, 32'd0);
        outv(120, 2'b01);
        outv(80, 2'b01);
        front_u.press_key();
        chko(3, 2'b00);
        // latch with delayed reset, then a power cycle with a reset pending
        setch(CH0_PAGE, ctl(HIGH_ACTING_UNBALANCED, RM_LATCH_DELAYED_RESET, 2'b00), 32'd100, 32'd0);
        outv(120, 2'b01);
        front_u.press_key();
        chko(3, 2'b01);
        rd(REG_STATUS, rv);
        chk(rv & 32'h11, 32'h11);
        outv(80, 2'b00);
        outv(120, 2'b01);
        front_u.press_key();
        outv(95, 2'b01);
        @(posedge mclk);
        rst_b <= 1'b0;
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        rd(REG_STATUS, rv);
        chk(rv & 32'h33, 32'h0);
        // standby after power up
        setch(CH0_PAGE, ctl(HIGH_ACTING_UNBALANCED, RM_AUTO, 2'b10), 32'd100, 32'd0);
        outv(120, 2'b00);
        outv(80, 2'b00);
        outv(120, 2'b01);
        // user input output resets, both active levels
        setch(CH1_PAGE, ctl(HIGH_ACTING_UNBALANCED, RM_AUTO, 2'b00), 32'd100, 32'd0);
        chko(3, 2'b11);
        for (int i = 0; i < 6; i++) begin
            lh = i[0];
            wr(REG_GCTRL, {23'h0, 1'b1, 4'h0, UF_NONE, lh});
            front_u.set_user(~lh);
            wr(REG_GCTRL, {23'h0, 1'b1, 4'h0, fn[i / 2], lh});
            front_u.set_user(lh);
            chko(3, fx[i / 2]);
            front_u.set_user(~lh);
            outv(80, 2'b00);
            outv(120, 2'b11);
        end
        // display reset of the output, then zeroing; shown flag gates both
        setch(CH0_PAGE, ctl(HIGH_ACTING_UNBALANCED, RM_AUTO, 2'b01), 32'd100, 32'd0);
        wr(REG_GCTRL, 32'h015);
        front_u.set_user(1'b1);
        chko(3, 2'b11);
        front_u.set_user(1'b0);
        wr(REG_GCTRL, 32'h115);
        front_u.set_user(1'b1);
        chko(3, 2'b10);
        front_u.set_user(1'b0);
        wr(REG_GCTRL, 32'h083);
        front_u.set_user(1'b1);
        chko(3, 2'b10);
        rdc(REG_OFFSET, 32'h0);
        front_u.set_user(1'b0);
        wr(REG_GCTRL, 32'h183);
        front_u.set_user(1'b1);
        chko(3, 2'b00);
        rdc(REG_OFFSET, 32'd120);
        front_u.set_user(1'b0);
        tally_and_finish();
    end
endmodule
